/* File: sim/far_model.sv */
// far port model: pushes words into and pops words from endpoint buffers
`timescale 1ns/10ps
module far_model (
   input wire logic clk,
   output logic push_valid,
   output logic [1:0] push_ep,
   output logic [15:0] push_data,
   input wire logic push_ready,
   output logic pop_ready,
   output logic [1:0] pop_ep,
   input wire logic [15:0] pop_data,
   input wire logic pop_valid
);
   // idle at time zero
   initial begin
      push_valid = 1'h0;
      push_ep = 2'h0;
      push_data = 16'h0000;
      pop_ready = 1'h0;
      pop_ep = 2'h0;
   end
   // ready is looked at on the falling edge so the taking edge is known
   task automatic push(input logic [1:0] ep, input logic [15:0] d);
      @(posedge clk);
      push_valid <= 1'h1;
      push_ep <= ep;
      push_data <= d;
      do @(negedge clk); while (push_ready !== 1'h1);
      @(posedge clk);
      push_valid <= 1'h0;
      push_data <= ~d; // released data must never look like the last word
   endtask
   // take one word after stalling some cycles
   task automatic pop(input logic [1:0] ep, input int stall, output logic [15:0] d);
      @(posedge clk);
      pop_ep <= ep;
      repeat (stall) @(posedge clk);
      pop_ready <= 1'h1;
      do @(negedge clk); while (pop_valid !== 1'h1);
      d = pop_data;
      @(posedge clk);
      pop_ready <= 1'h0;
   endtask
endmodule

/* File: sim/pport_properties.sv */
// assertion checker for the processor port pins
`timescale 1ns/10ps
`include "pport_defs.svh"
module pport_checker (
   input wire logic MCLK,
   input wire logic SRST,
   input wire logic [7:0] ADDR,
   input wire logic [15:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [15:0] RDATA,
   input wire logic IRQ,
   input wire logic DRQ,
   input wire logic NAND_BUSY_OE_N,
   input wire logic [2:0] IFACE_MODE
);
   logic [7:0] busy_r;
   logic [2:0] mode_r;
   default clocking @(posedge MCLK); endclocking
   default disable iff (SRST);
   // ------------
   // helper logic
   // ------------
   // busy stretch length, restarted whenever the line is let go
   always_ff @(posedge MCLK) begin
      if (SRST || NAND_BUSY_OE_N)
         busy_r <= 8'h00;
      else
         busy_r <= busy_r + 8'h01;
   end
   // mode field of the last data word, lines up with the pins one cycle on
   always_ff @(posedge MCLK) begin
      mode_r <= WDATA[3:1];
   end
   // ----------
   // properties
   // ----------
   a_notify_exclusive: assert property (!(IRQ && DRQ))
      else $error("irq and drq high together");
   a_mode_follow: assert property (WR && ADDR == `REG_CFG |=> IFACE_MODE == mode_r)
      else $error("mode pins differ from written field");
   a_unmapped_zero: assert property (
      RD && !ADDR[7] && ADDR > `REG_RDADDR |=> RDATA == 16'h0000)
      else $error("unmapped offset read not zero");
   a_rdata_hold: assert property (!RD |=> $stable(RDATA))
      else $error("read data moved without a read");
   a_rdaddr_shape: assert property (RD && ADDR == `REG_RDADDR |=>
      RDATA[14:8] == 7'h00 && (!RDATA[15] || RDATA[7:0] == {1'h1, RDATA[6:4], 4'h0}))
      else $error("read address word malformed");
   a_mask_off: assert property (
      WR && ADDR == `REG_MASK && WDATA == 16'h0000 |=> !IRQ && !DRQ)
      else $error("notification with all sources masked");
   a_busy_len: assert property ($rose(NAND_BUSY_OE_N) |-> busy_r == `NAND_BUSY_CYC)
      else $error("busy stretch has wrong length");
   a_busy_nand: assert property (
      $fell(NAND_BUSY_OE_N) |-> IFACE_MODE inside {3'h5, 3'h6})
      else $error("busy outside nand modes");
endmodule
bind pport_top pport_checker u_chk (.MCLK, .SRST, .ADDR, .WDATA, .WR, .RD, .RDATA, .IRQ,
   .DRQ, .NAND_BUSY_OE_N, .IFACE_MODE);

/* File: sim/tb_top.sv */
// self-checking bench for the processor port
`timescale 1ns/10ps
`include "pport_defs.svh"
module tb_top;
   typedef struct {logic [7:0] a; logic [15:0] w; logic [15:0] e;} row_s;
   logic MCLK = 1'h0, SRST = 1'h1, WR = 1'h0, RD = 1'h0;
   logic NAND_CLE = 1'h0, NAND_ALE = 1'h0, NAND_WE_N = 1'h1, NAND_RE_N = 1'h1;
   logic [7:0] ADDR = 8'h00, NAND_IO_IN = 8'h00, NAND_IO_OUT, b;
   logic [15:0] WDATA = 16'h0000, RDATA, FAR_PUSH_DATA, FAR_POP_DATA, v;
   logic IRQ, DRQ, NAND_IO_OE_N, NAND_BUSY_OUT, NAND_BUSY_OE_N;
   logic FAR_PUSH_VALID, FAR_PUSH_READY, FAR_POP_READY, FAR_POP_VALID;
   logic [1:0] FAR_PUSH_EP, FAR_POP_EP;
   logic [2:0] IFACE_MODE;
   int failures = 0, check_count = 0;
   // register rows: offset, word written, word read back
   row_s rows [8] = '{'{8'h02, 16'h000f, 16'h000f}, '{8'h04, 16'h0000, 16'h0000},
      '{8'h10, 16'hffff, 16'h0000}, '{8'h03, 16'h0000, 16'h000f},
      '{8'h01, 16'hffff, 16'h0000}, '{8'h05, 16'hffff, 16'h0080},
      '{8'h00, 16'h0001, 16'h0001}, '{8'h00, 16'h0000, 16'h0000}};
   always #2.5 MCLK = ~MCLK;
   pport_top #(.ID_MAKER(8'h3c)) u_dut (.MCLK, .SRST, .ADDR, .WDATA, .WR, .RD, .RDATA, .IRQ,
      .DRQ, .NAND_CLE, .NAND_ALE, .NAND_WE_N, .NAND_RE_N, .NAND_IO_IN, .NAND_IO_OUT,
      .NAND_IO_OE_N, .NAND_BUSY_OUT, .NAND_BUSY_OE_N, .IFACE_MODE, .FAR_PUSH_VALID,
      .FAR_PUSH_EP, .FAR_PUSH_DATA, .FAR_PUSH_READY, .FAR_POP_READY, .FAR_POP_EP,
      .FAR_POP_DATA, .FAR_POP_VALID); // maker code above is arbitrary
   far_model u_far (.clk(MCLK), .push_valid(FAR_PUSH_VALID), .push_ep(FAR_PUSH_EP),
      .push_data(FAR_PUSH_DATA), .push_ready(FAR_PUSH_READY), .pop_ready(FAR_POP_READY),
      .pop_ep(FAR_POP_EP), .pop_data(FAR_POP_DATA), .pop_valid(FAR_POP_VALID));
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("FAIL %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge MCLK);
      WR <= 1'h1;
      ADDR <= a;
      WDATA <= d;
      @(posedge MCLK);
      WR <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge MCLK);
      RD <= 1'h1;
      ADDR <= a;
      @(posedge MCLK);
      RD <= 1'h0;
      @(negedge MCLK);
      d = RDATA;
   endtask
   // nand write cycle; strobes held twice the three cycle minimum for the synchronisers
   task automatic nb(input logic c, input logic l, input logic [7:0] d);
      @(posedge MCLK);
      {NAND_CLE, NAND_ALE, NAND_IO_IN, NAND_WE_N} <= {c, l, d, 1'h0};
      repeat (6) @(posedge MCLK);
      NAND_WE_N <= 1'h1;
      repeat (6) @(posedge MCLK);
      {NAND_CLE, NAND_ALE, NAND_IO_IN} <= {2'h0, ~d};
   endtask
   task automatic nr(output logic [7:0] d);
      @(posedge MCLK);
      NAND_RE_N <= 1'h0;
      repeat (6) @(posedge MCLK);
      @(negedge MCLK);
      d = NAND_IO_OUT;
      @(posedge MCLK);
      NAND_RE_N <= 1'h1;
      repeat (6) @(posedge MCLK);
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // the sequence needs about three hundred cycles; cut a hang well after that
   initial begin
      #100000;
      failures++;
      wrap_up();
   end
   // main sequence
   initial begin
      repeat (5) @(posedge MCLK);
      SRST <= 1'h0;
      @(negedge MCLK);
      chk("reset pins", 16'h0003,
         {11'h000, NAND_BUSY_OUT, IRQ, DRQ, NAND_IO_OE_N, NAND_BUSY_OE_N});
      for (int m = 0; m < 8; m++) begin
         wr(`REG_CFG, 16'(m * 2));
         @(negedge MCLK);
         chk("mode pins", 16'(m), {13'h0000, IFACE_MODE});
      end
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].w);
         rd(rows[i].a, v);
         chk("register row", rows[i].e, v);
      end
      $display("register rows done");
      wr(8'h90, 16'h1234);
      wr(`BUF_BASE, 16'hbeef);
      u_far.pop(2'h1, 3, v);
      chk("far pop ep1", 16'h1234, v);
      u_far.pop(2'h0, 0, v);
      chk("far pop ep0", 16'hbeef, v);
      wr(`REG_DIR, 16'h0001);
      wr(`REG_STAT, 16'h000f);
      u_far.push(2'h0, 16'h5a5a);
      repeat (2) @(negedge MCLK);
      chk("irq on data", 16'h0001, {15'h0000, IRQ});
      rd(`REG_RDADDR, v);
      chk("read address", 16'h8080, v);
      rd(`BUF_BASE, v);
      chk("host pop ep0", 16'h5a5a, v);
      wr(`REG_STAT, 16'h0001);
      @(negedge MCLK);
      chk("irq cleared", 16'h0000, {15'h0000, IRQ});
      wr(`REG_MASK, 16'h0000);
      u_far.push(2'h0, 16'hc3a5);
      repeat (2) @(negedge MCLK);
      chk("irq masked", 16'h0000, {15'h0000, IRQ});
      rd(`REG_STAT, v);
      chk("status kept", 16'h0001, v);
      wr(`REG_MASK, 16'h0001);
      wr(`REG_CFG, 16'h0001);
      @(negedge MCLK);
      chk("drq ready", 16'h0002, {14'h0000, DRQ, IRQ});
      rd(`BUF_BASE, v);
      chk("dma pop ep0", 16'hc3a5, v);
      chk("drq drops", 16'h0000, {15'h0000, DRQ});
      $display("buffers and notification done");
      u_far.push(2'h0, 16'h9c3e);
      wr(`REG_CFG, 16'h000a);
      nb(1'h1, 1'h0, `NCMD_READ0);
      nb(1'h0, 1'h1, 8'h00);
      nb(1'h1, 1'h0, `NCMD_READ1);
      @(negedge MCLK);
      chk("busy after read", 16'h0000, {15'h0000, NAND_BUSY_OE_N});
      for (int i = 0; i < 40 && NAND_BUSY_OE_N !== 1'h1; i++) @(negedge MCLK);
      nr(b);
      chk("boot byte lo", 16'h003e, {8'h00, b});
      nr(b);
      chk("boot byte hi", 16'h009c, {8'h00, b});
      nb(1'h1, 1'h0, `NCMD_STATUS);
      nr(b);
      chk("status byte", 16'h0007, {13'h0000, b[7:5]});
      nb(1'h1, 1'h0, `NCMD_ID);
      nr(b);
      chk("maker byte", 16'h003c, {8'h00, b});
      $display("nand emulation done");
      // reduced mode has no identification, so the read shows an erased byte
      wr(`REG_CFG, 16'h000c);
      nb(1'h1, 1'h0, `NCMD_RESET);
      nb(1'h1, 1'h0, `NCMD_ID);
      nr(b);
      chk("id refused", 16'h00ff, {8'h00, b});
      $display("reduced nand done");
      SRST <= 1'h1;
      repeat (5) @(posedge MCLK);
      SRST <= 1'h0;
      @(negedge MCLK);
      chk("mode after reset", 16'h0000, {13'h0000, IFACE_MODE});
      $display("second reset done");
      wrap_up();
   end
endmodule

/* File: verilog/ep_fifo.sv */
// one endpoint buffer: flip-flop fifo with first-word-fall-through head
`timescale 1ns/10ps
module ep_fifo #(
   parameter int W = 16,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic push,
   input wire logic [W-1:0] push_data,
   output logic push_ready,
   input wire logic pop,
   output logic [W-1:0] pop_data,
   output logic pop_valid
);
   localparam int AW = $clog2(DEPTH);

   // -----------------------------------------------------------------
   // storage and pointers
   // -----------------------------------------------------------------
   logic [W-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0] count_r;
   logic do_push;
   logic do_pop;

   // pointers wrap by themselves, so depth must be a power of two
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("ep_fifo depth must be a power of two of at least 2");
   end

   assign push_ready = (count_r != (AW + 1)'(DEPTH));
   assign pop_valid = (count_r != '0);
   assign do_push = push & push_ready;
   assign do_pop = pop & pop_valid;
   assign pop_data = mem_r[rd_ptr_r];

   // data words carry no reset, only the pointers and fill count need one
   always_ff @(posedge clk) begin
      if (do_push) begin
         mem_r[wr_ptr_r] <= push_data;
      end
   end

   // pointer and fill count, push and pop may share a cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else begin
         if (do_push) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (do_pop) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
         if (do_push && !do_pop) begin
            count_r <= count_r + 1'b1;
         end else if (do_pop && !do_push) begin
            count_r <= count_r - 1'b1;
         end
      end
   end
endmodule

/* File: verilog/pport_defs.svh */
// shared offsets, field positions, reset values and timing counts of the processor port
`ifndef PPORT_DEFS_SVH
`define PPORT_DEFS_SVH

// -----------------------------------------------------------------
// register map, byte offsets on the 8-bit memory port address
// -----------------------------------------------------------------
`define REG_CFG 8'h00
`define REG_STAT 8'h01
`define REG_MASK 8'h02
`define REG_READY 8'h03
`define REG_DIR 8'h04
`define REG_RDADDR 8'h05
`define BUF_SPACE_BIT 7
`define BUF_BASE 8'h80
`define BUF_EP_LSB 4

// -----------------------------------------------------------------
// field positions and reset values
// -----------------------------------------------------------------
`define CFG_DMA_BIT 0
`define CFG_MODE_LSB 1
`define CFG_MODE_W 3
`define CFG_RST 16'h0000
`define MASK_RST 16'h0000
`define DIR_RST 16'h0000
`define RDADDR_VALID_BIT 15
`define DATA_W 16

// -----------------------------------------------------------------
// nand command codes and status byte
// -----------------------------------------------------------------
`define NCMD_READ0 8'h00
`define NCMD_READ1 8'h30
`define NCMD_PROG0 8'h80
`define NCMD_PROG1 8'h10
`define NCMD_STATUS 8'h70
`define NCMD_ID 8'h90
`define NCMD_RESET 8'hff
`define NST_NOWP_BIT 7
`define NST_RDY_BIT 6
`define NST_IDLE_BIT 5
`define NAND_EMPTY_BYTE 8'hff

// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define MCLK_MHZ 200
`define SYNC_CLK_MHZ 33
`define ASYNC_MBPS_X10 667
`define NAND_BUSY_NS 100
`define NAND_BUSY_CYC ((`NAND_BUSY_NS * `MCLK_MHZ + 999) / 1000)

`endif

/* File: verilog/pport_pkg.sv */
// types shared by the processor port design files
package pport_pkg;

   // host port personality, software selected
   typedef enum logic [2:0] {
      IF_PCRAM_MUX_SYNC = 3'h0,
      IF_PCRAM_MUX_ASYNC = 3'h1,
      IF_PCRAM_SYNC = 3'h2,
      IF_PCRAM_ASYNC = 3'h3,
      IF_SRAM_ASYNC = 3'h4,
      IF_NAND_EMULATION = 3'h5,
      IF_REDUCED_PSEUDO_NAND = 3'h6,
      IF_SPI_SLAVE = 3'h7
   } iface_mode_e;

   // nand front end, gray along idle-addr-busy-read
   typedef enum logic [2:0] {
      N_IDLE = 3'b000,
      N_ADDR = 3'b001,
      N_BUSY = 3'b011,
      N_READ = 3'b010,
      N_PROG = 3'b110,
      N_STAT = 3'b111,
      N_ID = 3'b101
   } nand_state_e;

endpackage

/* File: verilog/pport_top.sv */
// processor port: memory-mapped endpoint buffers, registers, notification, pseudo nand front end
//
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/10ps
`include "pport_defs.svh"
module pport_top #(
   parameter int NUM_EP = 4,
   parameter int DEPTH = 16,
   parameter logic [7:0] ID_MAKER = 8'h5a, // arbitrary value
   parameter logic [7:0] ID_DEVICE = 8'ha5 // arbitrary value
) (
   input wire logic MCLK,
   input wire logic SRST,
   input wire logic [7:0] ADDR,
   input wire logic [`DATA_W-1:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [`DATA_W-1:0] RDATA,
   output logic IRQ,
   output logic DRQ,
   input wire logic NAND_CLE,
   input wire logic NAND_ALE,
   input wire logic NAND_WE_N,
   input wire logic NAND_RE_N,
   input wire logic [7:0] NAND_IO_IN,
   output logic [7:0] NAND_IO_OUT,
   output logic NAND_IO_OE_N,
   output logic NAND_BUSY_OUT,
   output logic NAND_BUSY_OE_N,
   output logic [2:0] IFACE_MODE,
   input wire logic FAR_PUSH_VALID,
   input wire logic [$clog2(NUM_EP)-1:0] FAR_PUSH_EP,
   input wire logic [`DATA_W-1:0] FAR_PUSH_DATA,
   output logic FAR_PUSH_READY,
   input wire logic FAR_POP_READY,
   input wire logic [$clog2(NUM_EP)-1:0] FAR_POP_EP,
   output logic [`DATA_W-1:0] FAR_POP_DATA,
   output logic FAR_POP_VALID
);
   import pport_pkg::*;

   localparam int EPW = $clog2(NUM_EP);
   localparam int BUSY_CYC = `NAND_BUSY_CYC;
   localparam int SYNC_RATIO = `MCLK_MHZ / `SYNC_CLK_MHZ;

   // -----------------------------------------------------------------
   // elaboration checks
   // -----------------------------------------------------------------
   // buffer index lives in address bits 6:4 and status fits one word
   if (NUM_EP < 2 || NUM_EP > 8) begin : g_bad_ep
      $error("pport_top supports 2 to 8 endpoint buffers");
   end
   // one word per clock must cover the asynchronous throughput
   if (`MCLK_MHZ * 2 * 10 < `ASYNC_MBPS_X10) begin : g_bad_rate
      $error("core clock too slow for asynchronous throughput");
   end
   // a synchronous host clock needs at least two core clocks per period
   if (SYNC_RATIO < 2 || `DATA_W != 16) begin : g_bad_sync
      $error("core clock too slow for synchronous host clock");
   end
   if (BUSY_CYC < 1 || BUSY_CYC > 255) begin : g_bad_busy
      $error("nand busy time out of counter range");
   end

   // -----------------------------------------------------------------
   // declarations
   // -----------------------------------------------------------------
   logic [15:0] cfg_r;
   logic [NUM_EP-1:0] stat_r;
   logic [NUM_EP-1:0] mask_r;
   logic [NUM_EP-1:0] dir_r;
   logic [NUM_EP-1:0] ready;
   logic [NUM_EP-1:0] ready_d_r;
   logic [NUM_EP-1:0] push_ready;
   logic [NUM_EP-1:0] pop_valid;
   logic [`DATA_W-1:0] pop_data [NUM_EP];
   logic [NUM_EP-1:0] host_push;
   logic [NUM_EP-1:0] host_pop;
   logic [`DATA_W-1:0] host_wdata;
   iface_mode_e mode;
   logic dma_mode;
   logic nand_on;
   logic mem_on;
   logic is_buf;
   logic [EPW-1:0] mem_ep;
   logic rd_found;
   logic [EPW-1:0] rd_ep;
   logic [11:0] nin_s1_r;
   logic [11:0] nin_s2_r;
   logic we_n_d_r;
   logic re_n_d_r;
   logic cle;
   logic ale;
   logic [7:0] nio;
   logic we_rise;
   logic re_fall;
   logic cmd_we;
   logic addr_we;
   logic data_we;
   nand_state_e nstate_r;
   logic prog_r;
   logic half_r;
   logic [7:0] lo_r;
   logic id_idx_r;
   logic [EPW-1:0] nand_ep_r;
   logic [7:0] busy_cnt_r;
   logic [7:0] nand_out_r;
   logic nand_oe_n_r;
   logic nand_push;
   logic nand_pop;
   logic [7:0] nand_status;

   // -----------------------------------------------------------------
   // mode decode
   // -----------------------------------------------------------------
   // spi framing sits ahead of this port and lands on the same memory map
   assign mode = iface_mode_e'(cfg_r[`CFG_MODE_LSB +: `CFG_MODE_W]);
   assign nand_on = (mode == IF_NAND_EMULATION) || (mode == IF_REDUCED_PSEUDO_NAND);
   assign mem_on = !nand_on;
   assign dma_mode = cfg_r[`CFG_DMA_BIT];
   assign IFACE_MODE = cfg_r[`CFG_MODE_LSB +: `CFG_MODE_W];
   assign is_buf = ADDR[`BUF_SPACE_BIT];
   assign mem_ep = ADDR[`BUF_EP_LSB +: EPW];

   // -----------------------------------------------------------------
   // endpoint buffers
   // -----------------------------------------------------------------
   // dir 1: far side fills, host drains; dir 0: host fills, far side drains
   for (genvar i = 0; i < NUM_EP; i++) begin : g_ep
      logic sel_mem;
      logic sel_nand;
      assign sel_mem = mem_on && is_buf && (mem_ep == EPW'(i));
      assign sel_nand = nand_on && (nand_ep_r == EPW'(i));
      assign host_push[i] = !dir_r[i] && ((sel_mem && WR) || (sel_nand && nand_push));
      assign host_pop[i] = dir_r[i] && ((sel_mem && RD) || (sel_nand && nand_pop));
      assign ready[i] = dir_r[i] ? pop_valid[i] : push_ready[i];

      ep_fifo #(.W(`DATA_W), .DEPTH(DEPTH)) u_buf (
         .clk(MCLK),
         .rst(SRST),
         .push(dir_r[i] ? (FAR_PUSH_VALID && FAR_PUSH_EP == EPW'(i)) : host_push[i]),
         .push_data(dir_r[i] ? FAR_PUSH_DATA : host_wdata),
         .push_ready(push_ready[i]),
         .pop(dir_r[i] ? host_pop[i] : (FAR_POP_READY && FAR_POP_EP == EPW'(i))),
         .pop_data(pop_data[i]),
         .pop_valid(pop_valid[i])
      );
   end

   assign host_wdata = nand_on ? {nio, lo_r} : WDATA;
   assign FAR_PUSH_READY = dir_r[FAR_PUSH_EP] & push_ready[FAR_PUSH_EP];
   assign FAR_POP_VALID = ~dir_r[FAR_POP_EP] & pop_valid[FAR_POP_EP];
   assign FAR_POP_DATA = pop_data[FAR_POP_EP];

   // lowest-numbered host-read buffer holding data
   always_comb begin
      rd_found = 1'b0;
      rd_ep = '0;
      for (int k = NUM_EP - 1; k >= 0; k--) begin
         if (dir_r[k] && pop_valid[k]) begin
            rd_found = 1'b1;
            rd_ep = EPW'(k);
         end
      end
   end

   // -----------------------------------------------------------------
   // configuration registers
   // -----------------------------------------------------------------
   // changing dir with data inside leaves it for the new draining side
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         cfg_r <= `CFG_RST;
         mask_r <= NUM_EP'(`MASK_RST);
         dir_r <= NUM_EP'(`DIR_RST);
      end else if (WR && !is_buf) begin
         case (ADDR)
            `REG_CFG: cfg_r <= WDATA;
            `REG_MASK: mask_r <= WDATA[NUM_EP-1:0];
            `REG_DIR: dir_r <= WDATA[NUM_EP-1:0];
            default: ;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // sticky status and notification
   // -----------------------------------------------------------------
   // a buffer turning ready is the status change; set wins over write-one-clear
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         ready_d_r <= '0;
         stat_r <= '0;
      end else begin
         ready_d_r <= ready;
         if (WR && !is_buf && ADDR == `REG_STAT) begin
            stat_r <= (stat_r & ~WDATA[NUM_EP-1:0]) | (ready & ~ready_d_r);
         end else begin
            stat_r <= stat_r | (ready & ~ready_d_r);
         end
      end
   end

   // IRQ follows the sticky status and DRQ the live ready state; IRQ falls once cleared, DRQ once serviced, both when masked
   assign IRQ = !dma_mode && |(stat_r & mask_r);
   assign DRQ = dma_mode && |(ready & mask_r);

   // -----------------------------------------------------------------
   // read data, one cycle after the read strobe
   // -----------------------------------------------------------------
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         RDATA <= '0;
      end else if (RD) begin
         RDATA <= '0;
         if (is_buf) begin
            if (mem_on && dir_r[mem_ep] && pop_valid[mem_ep]) begin
               RDATA <= pop_data[mem_ep];
            end
         end else begin
            case (ADDR)
               `REG_CFG: RDATA <= cfg_r;
               `REG_STAT: RDATA <= 16'(stat_r);
               `REG_MASK: RDATA <= 16'(mask_r);
               `REG_READY: RDATA <= 16'(ready);
               `REG_DIR: RDATA <= 16'(dir_r);
               `REG_RDADDR: begin
                  RDATA <= 16'(`BUF_BASE | (8'(rd_ep) << `BUF_EP_LSB));
                  RDATA[`RDADDR_VALID_BIT] <= rd_found;
               end
               default: RDATA <= '0;
            endcase
         end
      end
   end

   // -----------------------------------------------------------------
   // nand pin synchronisers and strobe edges
   // -----------------------------------------------------------------
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         nin_s1_r <= 12'h300;
         nin_s2_r <= 12'h300;
         we_n_d_r <= 1'b1;
         re_n_d_r <= 1'b1;
      end else begin
         nin_s1_r <= {NAND_CLE, NAND_ALE, NAND_WE_N, NAND_RE_N, NAND_IO_IN};
         nin_s2_r <= nin_s1_r;
         we_n_d_r <= nin_s2_r[9];
         re_n_d_r <= nin_s2_r[8];
      end
   end

   assign cle = nin_s2_r[11];
   assign ale = nin_s2_r[10];
   assign nio = nin_s2_r[7:0];
   // bytes are taken on the rising write strobe, as flash does
   assign we_rise = nand_on && nin_s2_r[9] && !we_n_d_r;
   assign re_fall = nand_on && !nin_s2_r[8] && re_n_d_r;
   assign cmd_we = we_rise && cle && !ale;
   assign addr_we = we_rise && ale && !cle;
   assign data_we = we_rise && !ale && !cle;
   assign nand_push = data_we && prog_r && half_r && (nstate_r == N_PROG || nstate_r == N_ADDR);
   assign nand_pop = re_fall && half_r && (nstate_r == N_READ);

   always_comb begin
      nand_status = 8'h00;
      nand_status[`NST_NOWP_BIT] = 1'b1;
      nand_status[`NST_RDY_BIT] = (nstate_r != N_BUSY);
      nand_status[`NST_IDLE_BIT] = (nstate_r != N_BUSY);
   end

   // -----------------------------------------------------------------
   // nand command engine
   // -----------------------------------------------------------------
   // emulation reads the boot buffer 0 and ignores address bytes; the
   // reduced mode takes the last address byte as the buffer index
   always_ff @(posedge MCLK) begin
      if (SRST || !nand_on) begin
         nstate_r <= N_IDLE;
         prog_r <= 1'b0;
         half_r <= 1'b0;
         lo_r <= '0;
         id_idx_r <= 1'b0;
         nand_ep_r <= '0;
         busy_cnt_r <= '0;
      end else if (cmd_we) begin
         half_r <= 1'b0;
         id_idx_r <= 1'b0;
         case (nio)
            `NCMD_RESET: nstate_r <= N_IDLE;
            `NCMD_STATUS: nstate_r <= N_STAT;
            `NCMD_ID: begin
               // identification exists only while emulating real flash
               if (mode == IF_NAND_EMULATION) begin
                  nstate_r <= N_ID;
               end
            end
            `NCMD_READ0, `NCMD_PROG0: begin
               nstate_r <= N_ADDR;
               prog_r <= (nio == `NCMD_PROG0);
               nand_ep_r <= '0;
            end
            `NCMD_READ1: begin
               if (nstate_r == N_ADDR && !prog_r) begin
                  nstate_r <= N_BUSY;
                  busy_cnt_r <= 8'(BUSY_CYC);
               end
            end
            `NCMD_PROG1: begin
               if (nstate_r == N_PROG) begin
                  nstate_r <= N_BUSY;
                  busy_cnt_r <= 8'(BUSY_CYC);
               end
            end
            default: ;
         endcase
      end else if (addr_we && nstate_r == N_ADDR) begin
         if (mode == IF_REDUCED_PSEUDO_NAND) begin
            nand_ep_r <= nio[EPW-1:0];
         end
      end else if (data_we && prog_r && (nstate_r == N_ADDR || nstate_r == N_PROG)) begin
         nstate_r <= N_PROG;
         lo_r <= nio;
         half_r <= !half_r;
      end else if (re_fall) begin
         case (nstate_r)
            N_READ: half_r <= !half_r;
            N_ID: id_idx_r <= !id_idx_r;
            default: ;
         endcase
      end else if (nstate_r == N_BUSY) begin
         busy_cnt_r <= busy_cnt_r - 1'b1;
         if (busy_cnt_r == 8'h01) begin
            nstate_r <= prog_r ? N_IDLE : N_READ;
         end
      end
   end

   // -----------------------------------------------------------------
   // nand output byte, ready/busy and bus turnaround
   // -----------------------------------------------------------------
   // an empty buffer reads as erased flash rather than stalling the host
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         nand_out_r <= '0;
         nand_oe_n_r <= 1'b1;
         NAND_BUSY_OE_N <= 1'b1;
      end else begin
         nand_oe_n_r <= !(nand_on && !nin_s2_r[8]);
         NAND_BUSY_OE_N <= !(nand_on && nstate_r == N_BUSY);
         if (re_fall) begin
            case (nstate_r)
               N_STAT: nand_out_r <= nand_status;
               N_ID: nand_out_r <= id_idx_r ? ID_DEVICE : ID_MAKER;
               N_READ: begin
                  if (!pop_valid[nand_ep_r] || !dir_r[nand_ep_r]) begin
                     nand_out_r <= `NAND_EMPTY_BYTE;
                  end else begin
                     nand_out_r <= half_r ? pop_data[nand_ep_r][15:8] :
                        pop_data[nand_ep_r][7:0];
                  end
               end
               default: nand_out_r <= `NAND_EMPTY_BYTE;
            endcase
         end
      end
   end

   assign NAND_IO_OUT = nand_out_r;
   assign NAND_IO_OE_N = nand_oe_n_r;
   assign NAND_BUSY_OUT = 1'b0; // open drain, only pulls low
endmodule
